// ===== rtl/fpc_host.sv
// Host controller issuing protection and identification sequences
`timescale 1ns/1ps
`default_nettype none
module fpc_host
  import fpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  // User request side
  input wire logic req_valid,
  output logic req_ready,
  input wire fpc_req_t req,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic timeout_seen,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [23:0] flash_addr,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in
);
  // Sequencer states
  typedef enum logic [2:0] {
    FPC_IDLE, FPC_ISSUE, FPC_WAIT, FPC_RESPOND
  } fpc_state_t;
  logic rst_s1, rst_n; // Reset release synchroniser
  fpc_state_t state, next_state;
  fpc_req_t cur, next_cur;
  logic [2:0] step, next_step; // Bus cycle index in sequence
  logic [2:0] last_step; // Final index for current op
  fpc_cyc_t cyc; // Cycle to issue at this step
  logic start;
  logic done;
  logic [15:0] rdata;
  logic [15:0] next_rsp_data;
  logic next_rsp_valid;
  logic next_timeout_seen;
  logic [23:0] sector_base; // Sector base from top bits
  // Release reset through two flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end
  // Sector select keeps only A23-A16, low bits zero
  assign sector_base = {cur.addr[23:SECTOR_LSB], 16'h0000};
  // Length of each sequence; every protect op is framed by entry and exit
  always_comb begin
    case (cur.op)
      FPC_OP_ARRAY_READ: last_step = 3'd0;
      FPC_OP_RESET: last_step = 3'd0;
      FPC_OP_DPB_READ: last_step = 3'd5;
      FPC_OP_ID_READ: last_step = 3'd5;
      default: last_step = 3'd6;
    endcase
  end
  // Cycle table for each op and step
  always_comb begin
    cyc = '0;
    cyc.wr = 1'b1;
    if (cur.op == FPC_OP_ARRAY_READ) begin
      // Plain read, no unlock needed
      cyc.wr = 1'b0;
      cyc.addr = cur.addr;
    end else if (cur.op == FPC_OP_RESET) begin
      // Single reset write leaves ID mode or timeout
      // No buffer writes are issued, so the abort state never arises
      cyc.data = CMD_RESET;
    end else if (step == 3'd0) begin
      // Unlock cycles always complete in order
      cyc.addr = UNLOCK_ADDR_A;
      cyc.data = UNLOCK_DATA_A;
    end else if (step == 3'd1) begin
      cyc.addr = UNLOCK_ADDR_B;
      cyc.data = UNLOCK_DATA_B;
    end else if (step == 3'd2) begin
      // ID entry carries the sector for verify reads
      cyc.addr = (cur.op == FPC_OP_ID_READ) ? (sector_base | UNLOCK_ADDR_A) : UNLOCK_ADDR_A;
      cyc.data = (cur.op == FPC_OP_ID_READ) ? CMD_ID_ENTRY : CMD_DPB_ENTRY;
    end else if (step == 3'd3 && cur.op == FPC_OP_ID_READ) begin
      // Offset 0h-0Fh within the sector
      cyc.wr = 1'b0;
      cyc.addr = sector_base | {20'h00000, cur.addr[3:0]};
    end else if (step == 3'd3 && cur.op == FPC_OP_DPB_READ) begin
      // Status read at the sector
      cyc.wr = 1'b0;
      cyc.addr = sector_base;
    end else if (step == 3'd3) begin
      cyc.data = CMD_PROG;
    end else if (step == 3'd4 && cur.op != FPC_OP_ID_READ && cur.op != FPC_OP_DPB_READ) begin
      // Second cycle names the sector and the new state
      cyc.addr = sector_base;
      cyc.data = (cur.op == FPC_OP_DPB_CLEAR) ? DATA_CLEAR : DATA_SET;
    end else if (step == last_step - 3'd1) begin
      cyc.data = CMD_EXIT_A;
    end else begin
      cyc.data = CMD_EXIT_B;
    end
  end
  // Sequencer next state
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_step = step;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_timeout_seen = timeout_seen;
    start = 1'b0;
    case (state)
      FPC_IDLE: begin
        if (req_valid) begin
          next_cur = req;
          next_step = 3'd0;
          next_state = FPC_ISSUE;
        end
      end
      FPC_ISSUE: begin
        start = 1'b1;
        next_state = FPC_WAIT;
      end
      FPC_WAIT: begin
        if (done) begin
          if (!cyc.wr) begin
            // Keep read word; timeout bit flagged for a later reset
            next_rsp_data = rdata;
            next_timeout_seen = rdata[5];
          end
          if (step == last_step) begin
            next_state = FPC_RESPOND;
          end else begin
            next_step = step + 3'd1;
            next_state = FPC_ISSUE;
          end
        end
      end
      default: begin
        next_rsp_valid = 1'b1;
        next_state = FPC_IDLE;
      end
    endcase
  end
  assign req_ready = (state == FPC_IDLE);
  // Sequencer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FPC_IDLE;
      cur <= '0;
      step <= 3'd0;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      timeout_seen <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      step <= next_step;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      timeout_seen <= next_timeout_seen;
    end
  end
  // Pin-level cycle engine
  fpc_bus_cycle u_cycle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(start),
    .cyc(cyc),
    .done(done),
    .rdata(rdata),
    .ce_n(flash_ce_n),
    .oe_n(flash_oe_n),
    .we_n(flash_we_n),
    .addr(flash_addr),
    .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe),
    .dq_in(flash_dq_in)
  );
endmodule
`default_nettype wire

// ===== rtl/fpc_pkg.sv
// Package for the flash protection/identification host controller
// Notes on behaviour
// - Overlay entry: AA@555, 55@2AA, E0@555
// - A0 then sector write: 1 clear, 0 set
// - Exit: 90 then 0, back to array
// - Host always exits after any entry
// - Reset write leaves ID mode or timeout
// - Abort state needs full three-cycle reset
// - New sector verify needs exit and re-entry
// - Verify read is a fresh full access
package fpc_pkg;
  // Bus widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  // Unlock and command addresses and data
  localparam logic [23:0] UNLOCK_ADDR_A = 24'h000555;
  localparam logic [23:0] UNLOCK_ADDR_B = 24'h0002AA;
  localparam logic [15:0] UNLOCK_DATA_A = 16'h00AA;
  localparam logic [15:0] UNLOCK_DATA_B = 16'h0055;
  localparam logic [15:0] CMD_DPB_ENTRY = 16'h00E0;
  localparam logic [15:0] CMD_ID_ENTRY = 16'h0090;
  localparam logic [15:0] CMD_PROG = 16'h00A0;
  localparam logic [15:0] CMD_EXIT_A = 16'h0090;
  localparam logic [15:0] CMD_EXIT_B = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] DATA_CLEAR = 16'h0001;
  localparam logic [15:0] DATA_SET = 16'h0000;
  // Protection status words
  localparam logic [7:0] STAT_PROTECTED = 8'h00;
  localparam logic [7:0] STAT_UNPROTECTED = 8'h01;
  // Identification offsets
  localparam logic [23:0] ID_MAKER_OFS = 24'h000000;
  localparam logic [23:0] ID_PART_OFS = 24'h000001;
  localparam logic [23:0] ID_VERIFY_OFS = 24'h000002;
  localparam logic [23:0] ID_INDIC_OFS = 24'h000003;
  localparam logic [23:0] ID_LOWFEAT_OFS = 24'h00000C;
  localparam logic [23:0] ID_UPFEAT_OFS = 24'h00000D;
  localparam logic [15:0] LOWFEAT_RESET = 16'h0003;
  localparam int SECTOR_LSB = 16;
  // Indicator field positions
  localparam int IND_FACTORY_BIT = 7;
  localparam int IND_CUSTOMER_BIT = 6;
  localparam int IND_WP_BIT = 4;
  // Bus cycle timing, ns and derived cycles at 100 MHz
  localparam int CLK_NS = 10;
  localparam int ACCESS_NS = 70;
  localparam int WE_PULSE_NS = 35;
  localparam int CE_HIGH_NS = 20;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CE_HIGH_CYC = (CE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  // User operations
  typedef enum logic [2:0] {
    FPC_OP_ARRAY_READ,
    FPC_OP_DPB_SET,
    FPC_OP_DPB_CLEAR,
    FPC_OP_DPB_READ,
    FPC_OP_ID_READ,
    FPC_OP_RESET
  } fpc_op_t;
  // User request bundle
  typedef struct packed {
    fpc_op_t op;
    logic [23:0] addr;
  } fpc_req_t;
  // One flash bus cycle
  typedef struct packed {
    logic wr;
    logic [23:0] addr;
    logic [15:0] data;
  } fpc_cyc_t;
endpackage

// ===== rtl/fpc_bus_cycle.sv
// Single asynchronous flash bus cycle engine
`timescale 1ns/1ps
`default_nettype none
module fpc_bus_cycle
  import fpc_pkg::*;
#(
  parameter int ACC_CYC = ACCESS_CYC,
  parameter int WR_CYC = WE_CYC,
  parameter int GAP_CYC = CE_HIGH_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire fpc_cyc_t cyc,
  output logic done,
  output logic [15:0] rdata,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [23:0] addr,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in
);
  // Strobe phases
  typedef enum logic [1:0] {FPC_B_IDLE, FPC_B_STROBE, FPC_B_GAP} fpc_bstate_t;
  fpc_bstate_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic is_wr, next_is_wr;
  logic [23:0] next_addr;
  logic [15:0] next_dq_out, next_rdata;
  logic [15:0] dq_s1, dq_s2; // Pin synchroniser
  logic next_done;
  // Next-state logic; every cycle raises CE# then waits, so reads are fresh
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_is_wr = is_wr;
    next_addr = addr;
    next_dq_out = dq_out;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      FPC_B_IDLE: begin
        if (start) begin
          next_state = FPC_B_STROBE;
          next_is_wr = cyc.wr;
          next_addr = cyc.addr;
          next_dq_out = cyc.data;
          // Extra two cycles cover the input synchroniser on reads
          next_cnt = cyc.wr ? 8'(WR_CYC) : 8'(ACC_CYC + 2);
        end
      end
      FPC_B_STROBE: begin
        if (cnt > 8'h01) begin
          next_cnt = cnt - 8'h01;
        end else begin
          if (!is_wr) begin
            next_rdata = dq_s2;
          end
          next_state = FPC_B_GAP;
          next_cnt = 8'(GAP_CYC);
        end
      end
      default: begin
        // CE# high recovery before next cycle
        if (cnt > 8'h01) begin
          next_cnt = cnt - 8'h01;
        end else begin
          next_state = FPC_B_IDLE;
          next_done = 1'b1;
        end
      end
    endcase
  end
  // Registers; strobes come from flops for glitch-free pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FPC_B_IDLE;
      cnt <= 8'h00;
      is_wr <= 1'b0;
      addr <= 24'h000000;
      dq_out <= 16'h0000;
      rdata <= 16'h0000;
      done <= 1'b0;
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      is_wr <= next_is_wr;
      addr <= next_addr;
      dq_out <= next_dq_out;
      rdata <= next_rdata;
      done <= next_done;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      ce_n <= (next_state != FPC_B_STROBE);
      oe_n <= !(next_state == FPC_B_STROBE && !next_is_wr);
      we_n <= !(next_state == FPC_B_STROBE && next_is_wr);
      dq_oe <= (next_state == FPC_B_STROBE && next_is_wr);
    end
  end
endmodule
`default_nettype wire

// ===== verification/fpc_flash_model.sv
// Behavioural flash device: protection overlay and identification modes
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model #(
  parameter logic [15:0] MAKER = 16'h1A2B, // Arbitrary value
  parameter logic [15:0] PART = 16'h3C4D // Arbitrary value
) (
  input wire logic rst_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [23:0] addr,
  input wire logic [15:0] dq,
  output logic [15:0] q
);
  // Start values guard against a missed reset edge at time zero
  logic [1:0] mode = 2'h0; // 0 array, 1 overlay, 2 identification
  logic [1:0] step = 2'h0; // Unlock progress
  logic pend = 1'b0; // Second cycle of protect due
  logic ex = 1'b0; // Second cycle of exit due
  logic [7:0] sa; // Sector chosen at identification entry
  logic [255:0] unprot = '1; // One bit per sector, 1 means unprotected
  // No erase, suspend or lock register commands are modelled
  logic [23:0] la;
  logic [7:0] ld;
  logic [15:0] rd;
  logic [15:0] last = 16'h0000;
  // Sample 5 ns after the pulse opens, upper data byte dropped
  always @(negedge we_n) begin
    #5;
    la = addr;
    ld = dq[7:0];
  end
  // Command decode on the closing write edge
  always @(posedge we_n or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 2'h0;
      step <= 2'h0;
      pend <= 1'b0;
      ex <= 1'b0;
      unprot <= '1;
    end else if (ld == 8'hF0) begin
      mode <= 2'h0;
      step <= 2'h0;
      pend <= 1'b0;
      ex <= 1'b0;
    end else if (pend) begin
      unprot[la[23:16]] <= ld[0];
      pend <= 1'b0;
    end else if (ex) begin
      ex <= 1'b0;
      if (ld == 8'h00) mode <= 2'h0;
    end else if (mode != 2'h0 && ld == 8'h90) ex <= 1'b1;
    else if (mode == 2'h1 && ld == 8'hA0) pend <= 1'b1;
    else if (step == 2'h0) step <= {1'b0, la[10:0] == 11'h555 && ld == 8'hAA};
    else if (step == 2'h1) step <= (la[10:0] == 11'h2AA && ld == 8'h55) ? 2'h2 : 2'h0;
    else begin
      step <= 2'h0;
      if (la[10:0] == 11'h555 && ld == 8'hE0) mode <= 2'h1;
      if (la[10:0] == 11'h555 && ld == 8'h90) begin
        mode <= 2'h2;
        sa <= la[23:16];
      end
    end
  end
  // Read data by mode
  always_comb begin
    case (mode)
      2'h1: rd = {15'h0000, unprot[addr[23:16]]};
      2'h2: begin
        case (addr[3:0])
          4'h0: rd = MAKER;
          4'h1: rd = PART;
          4'h2: rd = {15'h0000, unprot[sa]};
          4'h3: rd = 16'hFFBF;
          4'hC: rd = 16'h0003;
          default: rd = 16'hFFFF;
        endcase
      end
      default: rd = addr[15:0] ^ 16'h5A5A;
    endcase
  end
  // Released bus shows the inverse of the last word, never a stale copy
  always @(posedge oe_n) last = rd;
  assign q = (!ce_n && !oe_n) ? rd : ~last;
endmodule
`default_nettype wire

// ===== verification/fpc_host_chk.sv
// Bus cycle checker for the host controller pins
`timescale 1ns/1ps
`default_nettype none
module fpc_host_chk
  import fpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire fpc_req_t req,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic timeout_seen,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [23:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic [15:0] flash_dq_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_strobe_excl: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("read and write strobes overlap");
  a_write_drives: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n)
    else $error("write without data drive or select");
  a_read_released: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data driven during read");
  a_read_access: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*8])
    else $error("read strobe shorter than access");
  a_ce_gap: assert property ($rose(flash_ce_n) |=> flash_ce_n)
    else $error("select high gap too short");
  a_entry_addr: assert property (!flash_we_n && flash_dq_out[7:0] == 8'hE0 |->
    flash_addr[10:0] == 11'h555) else $error("overlay entry at wrong address");
  a_unlock_two: assert property (!flash_we_n && flash_dq_out[7:0] == 8'h55 |->
    flash_addr[10:0] == 11'h2AA) else $error("second unlock at wrong address");
  a_timeout_copy: assert property (rsp_valid |=> timeout_seen == rsp_data[5])
    else $error("timeout flag differs from read bit 5");
endmodule
bind fpc_host fpc_host_chk u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .timeout_seen(timeout_seen), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));
`default_nettype wire

// ===== verification/fpc_host_bench.sv
// Self-checking bench for the flash protection host controller
`timescale 1ns/1ps
`default_nettype none
module fpc_host_bench;
  import fpc_pkg::*;
  localparam logic [15:0] MK = 16'h1A2B; // Arbitrary value
  localparam logic [15:0] PT = 16'h3C4D; // Arbitrary value
  logic core_clk, arst_n, req_valid, req_ready, rsp_valid, timeout_seen;
  fpc_req_t req;
  logic [15:0] rsp_data, dq_out, mdl_q;
  logic ce_n, oe_n, we_n, dq_oe;
  logic [23:0] fa;
  wire logic [15:0] dq_bus = dq_oe ? dq_out : mdl_q; // Resolved data pins
  logic [16:0] exq[$]; // Check flag and expected word
  logic prot[256]; // Mirror of protection state
  int mismatches = 0;
  int compares = 0;
  int seed = 32'hDC1125CD;
  logic [31:0] r;
  logic [16:0] note; // Oldest note, kept apart from the stimulus word
  logic [7:0] s;
  fpc_host DUT (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .timeout_seen(timeout_seen), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_addr(fa), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_bus));
  fpc_flash_model #(.MAKER(MK), .PART(PT)) u_flash (.rst_n(arst_n), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq(dq_bus), .q(mdl_q));
  always #5 core_clk = ~core_clk;
  function automatic logic [15:0] st(input logic p);
    st = {8'h00, p ? STAT_PROTECTED : STAT_UNPROTECTED};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One user operation, noting its expected word
  task automatic run(input fpc_op_t op, input logic [23:0] a, input logic c,
      input logic [15:0] e);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a};
    // Ready is looked at mid-cycle, where it has settled
    @(negedge core_clk);
    for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge core_clk);
    if (req_ready !== 1'b1) mismatches++;
    // This edge takes the request; valid drops just after it
    @(posedge core_clk);
    exq.push_back({c, e});
    req_valid <= 1'b0;
    for (int i = 0; i < 400 && exq.size() != 0; i++) @(posedge core_clk);
    if (exq.size() != 0) mismatches++;
  endtask
  task automatic arr();
    r = $random(seed);
    run(FPC_OP_ARRAY_READ, r[23:0], 1'b1, r[15:0] ^ 16'h5A5A);
  endtask
  task automatic end_sim();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Response watcher takes the oldest note
  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exq.size() == 0) begin
        mismatches++;
        $display("unexpected at %0t: response with nothing pending", $time);
      end else begin
        note = exq.pop_front();
        if (note[16]) check(rsp_data, note[15:0]);
      end
    end
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    foreach (prot[i]) prot[i] = 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    repeat (3) arr();
    // Set or clear at random offsets, read back here, a neighbour and via ID
    repeat (14) begin
      r = $random(seed);
      s = r[23:16];
      run(r[24] ? FPC_OP_DPB_SET : FPC_OP_DPB_CLEAR, r[23:0], 1'b0, 16'h0000);
      prot[s] = r[24];
      run(FPC_OP_DPB_READ, {s, ~r[15:0]}, 1'b1, st(prot[s]));
      run(FPC_OP_DPB_READ, {s ^ 8'h01, r[15:0]}, 1'b1, st(prot[s ^ 8'h01]));
      run(FPC_OP_ID_READ, {s, 16'h0002}, 1'b1, st(prot[s]));
      arr();
    end
    // Identification words
    run(FPC_OP_ID_READ, {s, 16'h0000}, 1'b1, MK);
    run(FPC_OP_ID_READ, {s, 16'h0001}, 1'b1, PT);
    run(FPC_OP_ID_READ, {s, 16'h0003}, 1'b1, 16'hFFBF);
    // Reserved bit 5 of the indicator reads 1, so the flag must rise
    check({15'h0000, timeout_seen}, 16'h0001);
    run(FPC_OP_ID_READ, {s, 16'h000C}, 1'b1, LOWFEAT_RESET);
    check({15'h0000, timeout_seen}, 16'h0000);
    run(FPC_OP_RESET, 24'h000000, 1'b0, 16'h0000);
    arr();
    // Mid-run reset drops every protection
    run(FPC_OP_DPB_SET, 24'h5A0000, 1'b0, 16'h0000);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    run(FPC_OP_DPB_READ, 24'h5A1234, 1'b1, st(1'b0));
    end_sim();
  end
endmodule
`default_nettype wire
